// File: hw/bcq_responder.sv
`timescale 1ns/1ps
`default_nettype none
module bcq_responder
    import bcq_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        cmd_valid,
    input  wire bcq_cmd_s    cmd,
    input  wire logic        cmd_intact,
    output var  logic        cmd_ready,
    input  wire logic [4:0]  proto_support,
    output var  logic [7:0]  st_proto,
    output var  logic [7:0]  st_attr,
    output var  logic [7:0]  st_idx,
    input  wire logic [7:0]  st_len,
    input  wire logic [7:0]  st_byte,
    output var  logic        rsp_valid,
    output var  bcq_rsp_s    rsp,
    input  wire logic        rsp_ready,
    output var  logic [7:0]  rsp_opcode
);

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    // Only the three tables held here count as supported
    function automatic logic [7:0] attr_count(input logic [7:0] p);
        logic [7:0] n;
        n = ZERO8;
        if (p == PROTO_PXE) begin
            n = PXE_ATTRS;
        end else if (p == PROTO_FC) begin
            n = FC_ATTRS;
        end else if (p == PROTO_FCOE) begin
            n = FCOE_ATTRS;
        end
        return n;
    endfunction

    // Fixed value width, or W_STRING when the store sets it
    function automatic logic [7:0] attr_width(input logic [7:0] p,
                                              input logic [7:0] a);
        logic [7:0] w;
        w = W_BYTE;
        if (p == PROTO_PXE) begin
            w = (a == PXE_VLAN_ID) ? W_UINT16 : W_BYTE;
        end else if (p == PROTO_FC) begin
            w = (a == ZERO8) ? W_BYTE : (a[0] ? W_STRING : W_UINT64);
        end else if (a == FCOE_WWPN) begin
            w = W_STRING;
        end else if (a == FCOE_LUN) begin
            w = W_UINT64;
        end else if (a == FCOE_FWD_VLAN) begin
            w = W_UINT16;
        end
        return w;
    endfunction

    function automatic logic [7:0] hdr_byte(input logic [2:0] i,
                                            input logic       f,
                                            input logic [7:0] p,
                                            input logic [7:0] n);
        logic [15:0] rc, rs;
        logic [7:0]  b;
        rc = f ? RC_FAIL : RC_OK;
        rs = f ? RSN_PARAM : RSN_NONE;
        b  = ZERO8;
        case (i)
            3'h0: b = rc[15:8];
            3'h1: b = rc[7:0];
            3'h2: b = rs[15:8];
            3'h3: b = rs[7:0];
            3'h6: b = p;
            3'h7: b = n;
            default: b = ZERO8;
        endcase
        return b;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    bcq_state_e  state_q, state_d;
    logic [2:0]  hidx_q, hidx_d;
    logic [7:0]  proto_q, proto_d;
    logic        fail_q, fail_d;
    logic [7:0]  count_q, count_d;
    logic [7:0]  attr_q, attr_d;
    logic [7:0]  idx_q, idx_d;
    logic [7:0]  len_q, len_d;
    logic        valid_q, valid_d;
    bcq_rsp_s    rsp_q, rsp_d;
    logic        ready_q, ready_d;
    logic        ld, take, sup, known;
    logic [7:0]  len_eff;
    logic [7:0]  wfix;
    logic        attr_last;
    logic [7:0]  sup_vec;

    // Output register may be refilled when empty or being drained
    assign ld    = !valid_q || rsp_ready;
    // Damaged or foreign packets never reach this block's reply
    assign take  = cmd_valid && ready_q && cmd_intact
                   && (cmd.opcode == CMD_OPCODE);
    assign known = (cmd.proto <= PROTO_NVME);
    // Support bits padded so every three-bit code indexes in range
    assign sup_vec = {3'h0, proto_support};
    assign sup   = known && sup_vec[cmd.proto[2:0]]
                   && (attr_count(cmd.proto) != ZERO8);
    assign wfix  = attr_width(proto_q, attr_q);
    // Strings pass through at the stored length, no terminator
    assign len_eff = (st_len == ZERO8 || wfix == W_STRING)
                     ? st_len : wfix;
    assign attr_last = (attr_q == 8'(count_q - 8'h01));

    // ------------------------------------------------------------
    // Next state and reply byte
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        hidx_d  = hidx_q;
        proto_d = proto_q;
        fail_d  = fail_q;
        count_d = count_q;
        attr_d  = attr_q;
        idx_d   = idx_q;
        len_d   = len_q;
        valid_d = valid_q && !rsp_ready;
        rsp_d   = rsp_q;
        case (state_q)
            ST_IDLE: begin
                if (take) begin
                    proto_d = known ? cmd.proto : PROTO_UNKNOWN;
                    fail_d  = !sup;
                    count_d = sup ? attr_count(cmd.proto) : ZERO8;
                    hidx_d  = 3'h0;
                    attr_d  = ZERO8;
                    idx_d   = ZERO8;
                    state_d = ST_HDR;
                end
            end
            ST_HDR: begin
                if (ld) begin
                    valid_d   = 1'b1;
                    rsp_d.data = hdr_byte(hidx_q, fail_q, proto_q,
                                          count_q);
                    rsp_d.last = (hidx_q == HDR_LAST)
                                 && (count_q == ZERO8);
                    if (hidx_q == HDR_LAST) begin
                        state_d = (count_q == ZERO8) ? ST_IDLE : ST_LEN;
                    end else begin
                        hidx_d = 3'(hidx_q + 3'h1);
                    end
                end
            end
            ST_LEN: begin
                // Length byte leads: high half of the entry word
                if (ld) begin
                    valid_d    = 1'b1;
                    rsp_d.data = len_eff;
                    rsp_d.last = 1'b0;
                    len_d      = len_eff;
                    state_d    = ST_TYPE;
                end
            end
            ST_TYPE: begin
                if (ld) begin
                    valid_d    = 1'b1;
                    rsp_d.data = attr_q;
                    rsp_d.last = (len_q == ZERO8) && attr_last;
                    idx_d      = ZERO8;
                    if (len_q != ZERO8) begin
                        state_d = ST_VAL;
                    end else if (attr_last) begin
                        state_d = ST_IDLE;
                    end else begin
                        attr_d  = 8'(attr_q + 8'h01);
                        state_d = ST_LEN;
                    end
                end
            end
            ST_VAL: begin
                // Value bytes come straight from the settings store
                if (ld) begin
                    valid_d    = 1'b1;
                    rsp_d.data = st_byte;
                    rsp_d.last = 1'b0;
                    if (idx_q == 8'(len_q - 8'h01)) begin
                        rsp_d.last = attr_last;
                        if (attr_last) begin
                            state_d = ST_IDLE;
                        end else begin
                            attr_d  = 8'(attr_q + 8'h01);
                            state_d = ST_LEN;
                        end
                    end else begin
                        idx_d = 8'(idx_q + 8'h01);
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        ready_d = (state_d == ST_IDLE);
    end

    // Plain registers only; a new query is refused while busy
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            hidx_q  <= 3'h0;
            proto_q <= ZERO8;
            fail_q  <= 1'b0;
            count_q <= ZERO8;
            attr_q  <= ZERO8;
            idx_q   <= ZERO8;
            len_q   <= ZERO8;
            valid_q <= 1'b0;
            rsp_q   <= '0;
            ready_q <= 1'b0;
        end else begin
            state_q <= state_d;
            hidx_q  <= hidx_d;
            proto_q <= proto_d;
            fail_q  <= fail_d;
            count_q <= count_d;
            attr_q  <= attr_d;
            idx_q   <= idx_d;
            len_q   <= len_d;
            valid_q <= valid_d;
            rsp_q   <= rsp_d;
            ready_q <= ready_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign cmd_ready  = ready_q;
    assign st_proto   = proto_q;
    assign st_attr    = attr_q;
    assign st_idx     = idx_q;
    assign rsp_valid  = valid_q;
    assign rsp        = rsp_q;
    assign rsp_opcode = RSP_OPCODE;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_reply_opcode;
        @(posedge clk) disable iff (!resetn)
        valid_q |-> rsp_opcode == RSP_OPCODE;
    endproperty
    a_reply_opcode: assert property (p_reply_opcode)
        else $error("reply opcode wrong");

    property p_always_reply;
        @(posedge clk) disable iff (!resetn)
        take && !valid_q |=> !ready_q ##1 valid_q;
    endproperty
    a_always_reply: assert property (p_always_reply)
        else $error("accepted query got no reply byte");

    property p_foreign_ignored;
        @(posedge clk) disable iff (!resetn)
        state_q == ST_IDLE && cmd_valid && cmd.opcode != CMD_OPCODE
        |=> state_q == ST_IDLE;
    endproperty
    a_foreign_ignored: assert property (p_foreign_ignored)
        else $error("foreign opcode started a reply");

    property p_unknown_proto;
        @(posedge clk) disable iff (!resetn)
        take && cmd.proto > PROTO_NVME
        |=> proto_q == PROTO_UNKNOWN && fail_q;
    endproperty
    a_unknown_proto: assert property (p_unknown_proto)
        else $error("reserved protocol not reported unknown");

    property p_unsupported_fails;
        @(posedge clk) disable iff (!resetn)
        take && !sup_vec[cmd.proto[2:0]] |=> fail_q;
    endproperty
    a_unsupported_fails: assert property (p_unsupported_fails)
        else $error("unsupported protocol did not fail");

    property p_pxe_count;
        @(posedge clk) disable iff (!resetn)
        take && cmd.proto == PROTO_PXE && proto_support[0]
        |=> count_q == PXE_ATTRS && !fail_q;
    endproperty
    a_pxe_count: assert property (p_pxe_count)
        else $error("PXE entry count wrong");

    property p_pxe_vlan_len;
        @(posedge clk) disable iff (!resetn)
        state_q == ST_LEN && ld && proto_q == PROTO_PXE
        && attr_q == PXE_VLAN_ID && st_len != ZERO8
        |=> rsp_q.data == W_UINT16 && valid_q;
    endproperty
    a_pxe_vlan_len: assert property (p_pxe_vlan_len)
        else $error("VLAN id entry length not two");

    property p_fc_lun_len;
        @(posedge clk) disable iff (!resetn)
        state_q == ST_LEN && ld && proto_q == PROTO_FC
        && attr_q == FCOE_LUN && st_len != ZERO8
        |=> rsp_q.data == W_UINT64;
    endproperty
    a_fc_lun_len: assert property (p_fc_lun_len)
        else $error("FC LUN entry length not eight");

    property p_empty_entry;
        @(posedge clk) disable iff (!resetn)
        state_q == ST_LEN && ld && st_len == ZERO8
        |=> rsp_q.data == ZERO8 ##1 (state_q != ST_VAL);
    endproperty
    a_empty_entry: assert property (p_empty_entry)
        else $error("valueless entry not sent with length zero");

    property p_hold_stall;
        @(posedge clk) disable iff (!resetn)
        valid_q && !rsp_ready |=> valid_q && $stable(rsp_q);
    endproperty
    a_hold_stall: assert property (p_hold_stall)
        else $error("reply byte changed while stalled");

    c_fail_reply: cover property (@(posedge clk) disable iff (!resetn)
        fail_q && valid_q && rsp_q.last);
    c_pxe_reply: cover property (@(posedge clk) disable iff (!resetn)
        proto_q == PROTO_PXE && valid_q && rsp_q.last && !fail_q);
    c_fc_reply: cover property (@(posedge clk) disable iff (!resetn)
        proto_q == PROTO_FC && valid_q && rsp_q.last && !fail_q);

endmodule
`default_nettype wire

// File: hw/bcq_pkg.sv
// What this block does
// - Query opcode 0x2D carries a protocol type
// - Protocol codes 0x00-0x04, rest reserved
// - Unsupported protocol fails with parameter invalid
// - Intact query always gets a reply
// - Reply opcode is 0xAD
// - Reply reports settings held in nonvolatile store
// - Codes, reserved, type, count, then entries
// - Reply type echoes protocol, 0xFF if unknown
// - Return attribute set of requested protocol; code has sets for PXE, FC and FCoE only, iSCSI and NVMe fail
// - Entry word: type low, length high byte
// - Valueless supported attributes sent with length zero
// - Strings sent unterminated, length gives extent
// - PXE type 0x00 is 16-bit VLAN id
// - PXE type 0x01 is VLAN enable byte
// - FC: boot choice, eight name/LUN pairs
// - FCoE: choice, name, LUN, VLAN, boot flag
package bcq_pkg;

    // ------------------------------------------------------------
    // Opcodes and protocol codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_OPCODE    = 8'h2D;
    localparam logic [7:0] RSP_OPCODE    = 8'hAD;
    localparam logic [7:0] PROTO_PXE     = 8'h00;
    localparam logic [7:0] PROTO_ISCSI   = 8'h01;
    localparam logic [7:0] PROTO_FCOE    = 8'h02;
    localparam logic [7:0] PROTO_FC      = 8'h03;
    localparam logic [7:0] PROTO_NVME    = 8'h04;
    localparam logic [7:0] PROTO_UNKNOWN = 8'hFF;

    // ------------------------------------------------------------
    // Response and reason codes
    // ------------------------------------------------------------
    localparam logic [15:0] RC_OK        = 16'h0000;
    localparam logic [15:0] RC_FAIL      = 16'h0001;
    localparam logic [15:0] RSN_NONE     = 16'h0000;
    localparam logic [15:0] RSN_PARAM    = 16'h0002;

    // ------------------------------------------------------------
    // Layout, attribute counts and value widths
    // ------------------------------------------------------------
    localparam logic [2:0] HDR_LAST      = 3'h7;
    localparam logic [7:0] PXE_ATTRS     = 8'h02;
    localparam logic [7:0] FC_ATTRS      = 8'h11;
    localparam logic [7:0] FCOE_ATTRS    = 8'h05;
    localparam logic [7:0] W_STRING      = 8'h00;
    localparam logic [7:0] W_BYTE        = 8'h01;
    localparam logic [7:0] W_UINT16      = 8'h02;
    localparam logic [7:0] W_UINT64      = 8'h08;
    localparam logic [7:0] PXE_VLAN_ID   = 8'h00;
    localparam logic [7:0] FCOE_WWPN     = 8'h01;
    localparam logic [7:0] FCOE_LUN      = 8'h02;
    localparam logic [7:0] FCOE_FWD_VLAN = 8'h03;
    localparam logic [7:0] ZERO8         = 8'h00;

    // ------------------------------------------------------------
    // Carriers and states
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] proto;
    } bcq_cmd_s;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } bcq_rsp_s;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_HDR  = 5'b00010,
        ST_LEN  = 5'b00100,
        ST_TYPE = 5'b01000,
        ST_VAL  = 5'b10000
    } bcq_state_e;

endpackage

// File: test/bcq_store_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Settings store seen through the responder's lookup ports
// ------------------------------------------------------------
module bcq_store_model
    import bcq_pkg::*;
(
    input  wire logic [7:0] st_proto,
    input  wire logic [7:0] st_attr,
    input  wire logic [7:0] st_idx,
    output var  logic [7:0] st_len,
    output var  logic [7:0] st_byte
);
    // Strings: odd FC types up to 0x0F and the FCoE target name
    function automatic logic is_str(input logic [7:0] p, input logic [7:0] a);
        return (p == PROTO_FC && a[0] && a <= 8'h0F) ||
               (p == PROTO_FCOE && a == 8'h01);
    endfunction

    // Some entries stay empty so zero lengths get exercised
    function automatic logic [7:0] len_of(input logic [7:0] p,
                                          input logic [7:0] a);
        case (p)
            PROTO_PXE:  return (a == 8'h00) ? 8'h02 : 8'h00;
            PROTO_FC: begin
                if (a == 8'h00) return 8'h01;
                if (a >= 8'h10) return 8'h00;
                return a[0] ? 8'h03 : 8'h08;
            end
            PROTO_FCOE: begin
                case (a)
                    8'h00:   return 8'h01;
                    8'h01:   return 8'h05;
                    8'h02:   return 8'h08;
                    8'h03:   return 8'h02;
                    default: return 8'h01;
                endcase
            end
            default:    return 8'h00;
        endcase
    endfunction

    // ASCII letters for strings, no null byte; mixed bits for integers
    function automatic logic [7:0] val(input logic [7:0] p,
                                       input logic [7:0] a,
                                       input logic [7:0] i);
        if (is_str(p, a)) return 8'h41 + a + i;
        return 8'hC0 ^ (a + {i[3:0], 4'h0}) ^ p;
    endfunction

    // Combinational answer, same cycle as the lookup
    assign st_len  = len_of(st_proto, st_attr);
    assign st_byte = val(st_proto, st_attr, st_idx);
endmodule
`default_nettype wire

// File: test/tb_bcq_responder.sv
`timescale 1ns/1ps
`default_nettype none
module tb_bcq_responder
    import bcq_pkg::*;
;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    logic       cmd_valid = 1'b0;
    bcq_cmd_s   cmd = '0;
    logic       cmd_intact = 1'b0;
    logic       cmd_ready;
    logic [4:0] proto_support = 5'h1F;
    logic [7:0] st_proto, st_attr, st_idx, st_len, st_byte;
    logic       rsp_valid;
    bcq_rsp_s   rsp;
    logic       rsp_ready = 1'b0;
    logic [7:0] rsp_opcode;
    int         mismatches = 0;
    int         num_checks = 0;
    logic [7:0] exp_q[$];

    bcq_responder bcq_responder_i (.clk(clk), .resetn(resetn),
        .cmd_valid(cmd_valid), .cmd(cmd), .cmd_intact(cmd_intact),
        .cmd_ready(cmd_ready), .proto_support(proto_support),
        .st_proto(st_proto), .st_attr(st_attr), .st_idx(st_idx),
        .st_len(st_len), .st_byte(st_byte), .rsp_valid(rsp_valid),
        .rsp(rsp), .rsp_ready(rsp_ready), .rsp_opcode(rsp_opcode));
    bcq_store_model bcq_store_model_i (.st_proto(st_proto),
        .st_attr(st_attr), .st_idx(st_idx), .st_len(st_len),
        .st_byte(st_byte));

    // Clock at 50 ns period
    initial begin
        forever #25 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Expected byte stream, header first, then entries length-first
    function automatic void build(input logic [7:0] p);
        logic       ok;
        logic [7:0] n, l;
        ok = (p == PROTO_PXE || p == PROTO_FCOE || p == PROTO_FC) &&
             proto_support[p[2:0]];
        n = !ok ? 8'h00 : (p == PROTO_PXE) ? 8'h02 :
            (p == PROTO_FC) ? 8'h11 : 8'h05;
        exp_q.delete();
        exp_q = '{8'h00, ok ? 8'h00 : 8'h01, 8'h00, ok ? 8'h00 : 8'h02,
                  8'h00, 8'h00, (p > 8'h04) ? 8'hFF : p, n};
        for (int a = 0; a < n; a++) begin
            l = bcq_store_model_i.len_of(p, 8'(a));
            exp_q.push_back(l);
            exp_q.push_back(8'(a));
            for (int i = 0; i < l; i++)
                exp_q.push_back(bcq_store_model_i.val(p, 8'(a), 8'(i)));
        end
    endfunction

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    // Holds the query until taken; refused ones held six cycles
    task automatic query(input logic [7:0] op, input logic [7:0] p,
                         input logic intact);
        int w;
        w = 0;
        @(negedge clk);
        cmd_valid  = 1'b1;
        cmd        = '{opcode: op, proto: p};
        cmd_intact = intact;
        if (intact && op == CMD_OPCODE) begin
            while (cmd_ready !== 1'b1 && w < 200) begin
                @(negedge clk);
                w++;
            end
            @(negedge clk);
            cmd_valid = 1'b0;
            check(16'(cmd_ready), 16'h0000);
            check(16'(st_proto), 16'((p > 8'h04) ? 8'hFF : p));
            check(16'(rsp_valid), 16'h0000);
            @(negedge clk);
            check(16'(rsp_valid), 16'h0001);
        end else begin
            repeat (6) begin
                @(negedge clk);
                check(16'(rsp_valid), 16'h0000);
                check(16'(cmd_ready), 16'h0001);
            end
            cmd_valid = 1'b0;
        end
    endtask

    // Sink that may stall every third cycle; bytes compared as taken
    task automatic collect(input logic stall);
        int       k, w;
        logic     held;
        bcq_rsp_s prev;
        k = 0;
        w = 0;
        held = 1'b0;
        prev = '0;
        while (k < exp_q.size() && w < 2000) begin
            if (held) check(16'(rsp), 16'(prev));
            rsp_ready = !stall || (w % 3 != 1);
            held = (rsp_valid === 1'b1) && !rsp_ready;
            prev = rsp;
            if (rsp_valid === 1'b1 && rsp_ready) begin
                check(16'(rsp.data), 16'(exp_q[k]));
                check(16'(rsp.last), 16'(k == exp_q.size() - 1));
                k++;
            end
            @(negedge clk);
            w++;
        end
        rsp_ready = 1'b0;
        check(16'(k), 16'(exp_q.size()));
        check(16'(rsp_valid), 16'h0000);
    endtask

    task automatic run(input logic [7:0] p, input logic stall);
        build(p);
        query(CMD_OPCODE, p, 1'b1);
        collect(stall);
    endtask

    // ------------------------------------------------------------
    // Watchdog and test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        end_of_test();
    end

    initial begin
        logic [7:0] protos[7];
        protos = '{8'h00, 8'h02, 8'h03, 8'h01, 8'h04, 8'h05, 8'hFF};
        repeat (4) @(negedge clk);
        check(16'(cmd_ready), 16'h0000);
        check(16'(rsp_opcode), 16'h00AD);
        resetn = 1'b1;
        // Every protocol code, sink alternately stalling
        foreach (protos[j]) run(protos[j], 1'(j % 2));
        // Known protocols turned off at this destination
        proto_support = 5'h00;
        run(PROTO_PXE, 1'b0);
        proto_support = 5'h1B;
        run(PROTO_FCOE, 1'b1);
        proto_support = 5'h1F;
        // Damaged or foreign queries draw no reply
        query(8'h2C, PROTO_PXE, 1'b1);
        query(CMD_OPCODE, PROTO_PXE, 1'b0);
        // Reset in mid-reply, then a clean reply again
        build(PROTO_FC);
        query(CMD_OPCODE, PROTO_FC, 1'b1);
        resetn = 1'b0;
        @(negedge clk);
        check(16'(rsp_valid), 16'h0000);
        check(16'(rsp_opcode), 16'h00AD);
        resetn = 1'b1;
        run(PROTO_FC, 1'b1);
        check(16'(rsp_opcode), 16'h00AD);
        end_of_test();
    end
endmodule
`default_nettype wire
